//--- atc_cmp_unit.sv
// Unsigned magnitude compare with selectable sense
`timescale 1ns/10ps
module atc_cmp_unit #(
  parameter int WIDTH = 10
) (
  input wire logic [WIDTH-1:0] result_i,
  input wire logic [WIDTH-1:0] level_i,
  input wire logic sense_ge_i,
  output logic hit_o
);

  wire ge_w = (result_i >= level_i);

  // Sense 1 is at-or-above, 0 is strictly below
  assign hit_o = sense_ge_i ? ge_w : ~ge_w;

endmodule // atc_cmp_unit

//--- atc_ctrl.sv
// Trigger, compare and result register control of the converter, on classic Wishbone
//
// Overview of operation
// - Active flag set at start, cleared at end
// - Bit 6 picks software or hardware trigger
// - Software trigger: start on control write
// - Hardware trigger: start on trigger input
// - Bit 5 enables automatic compare
// - Bit 4 picks at-or-above versus below
// - Upper result holds top two bits
// - Eight-bit mode keeps upper result zero, unless a ten-bit result loads in the cycle of the mode write
// - Lower result holds low eight bits
// - Results load unless compare is false
// - Ten-bit upper read locks until lower read or config write
// - Results completed while locked are discarded
// - Eight-bit mode has no read lock
// - Upper compare used only in ten-bit
// - Lower compare used in both resolutions
// - Done flag set only if compare holds
// - Done cleared by control write or lower read
// - Control write aborts; in software trigger mode it also restarts unless off
// - Mode 00 is eight-bit, 10 ten-bit
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
module atc_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_trigger_in_i,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic conv_ten_bit_o,
  output logic [4:0] conv_channel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic ack_reg;
  logic [31:0] rdata_reg;
  wire req_w = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_w = req_w & wb_we_i & wb_sel_i[0];
  wire rd_w = req_w & ~wb_we_i;
  wire [7:0] ofs_w = wb_adr_i[7:0];
  wire [7:0] wbyte_w = wb_dat_i[7:0];
  wire hit_chan_w = (ofs_w == atc_pkg::OFS_CHAN_START);
  wire hit_trig_w = (ofs_w == atc_pkg::OFS_TRIG_CMP);
  wire hit_rup_w = (ofs_w == atc_pkg::OFS_RES_UPPER);
  wire hit_rlo_w = (ofs_w == atc_pkg::OFS_RES_LOWER);
  wire hit_cup_w = (ofs_w == atc_pkg::OFS_CMPV_UPPER);
  wire hit_clo_w = (ofs_w == atc_pkg::OFS_CMPV_LOWER);
  wire hit_cfg_w = (ofs_w == atc_pkg::OFS_CONFIG);
  wire wr_chan_w = wr_w & hit_chan_w;
  wire wr_trig_w = wr_w & hit_trig_w;
  wire wr_cup_w = wr_w & hit_cup_w;
  wire wr_clo_w = wr_w & hit_clo_w;
  wire wr_cfg_w = wr_w & hit_cfg_w;
  wire rd_rup_w = rd_w & hit_rup_w;
  wire rd_rlo_w = rd_w & hit_rlo_w;

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  logic [4:0] chan_reg;
  logic trig_sel_reg;
  logic cmp_en_reg;
  logic cmp_ge_reg;
  logic [1:0] mode_reg;
  logic [1:0] cmpv_up_reg;
  logic [7:0] cmpv_lo_reg;
  logic [1:0] res_up_reg;
  logic [7:0] res_lo_reg;
  logic done_reg;
  logic lock_reg;
  atc_pkg::atc_state_t state_reg;
  atc_pkg::atc_state_t state_next;

  // Mode bit 3 alone decides; reserved codes follow their high bit
  wire ten_bit_w = mode_reg[1];
  wire [1:0] mode_wr_w = wbyte_w[atc_pkg::MODE_LSB +: atc_pkg::MODE_W];
  wire [4:0] chan_wr_w = wbyte_w[atc_pkg::CHAN_LSB +: atc_pkg::CHAN_W];
  wire chan_on_w = (chan_wr_w != atc_pkg::CHAN_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Hardware trigger pin, two-stage synchroniser then rising edge
  logic trg_s1_reg;
  logic trg_s2_reg;
  logic trg_s3_reg;
  wire trg_rise_w = trg_s2_reg & ~trg_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and result path
  wire [9:0] level10_w = {cmpv_up_reg, cmpv_lo_reg};
  wire hit10_w;
  wire hit8_w;

  atc_cmp_unit #(
    .WIDTH(atc_pkg::RES_W)
  ) u_cmp10 (
    .result_i(conv_data_i),
    .level_i(level10_w),
    .sense_ge_i(cmp_ge_reg),
    .hit_o(hit10_w)
  );

  // Eight-bit compare never looks at the upper compare bits
  atc_cmp_unit #(
    .WIDTH(atc_pkg::BYTE_W)
  ) u_cmp8 (
    .result_i(conv_data_i[7:0]),
    .level_i(cmpv_lo_reg),
    .sense_ge_i(cmp_ge_reg),
    .hit_o(hit8_w)
  );

  wire cmp_hit_w = ten_bit_w ? hit10_w : hit8_w;
  wire pass_w = ~cmp_en_reg | cmp_hit_w;
  wire finish_w = conv_done_i & (state_reg == atc_pkg::ST_BUSY);
  // Lock only matters in ten-bit mode
  wire blocked_w = lock_reg & ten_bit_w;
  wire load_w = finish_w & pass_w & ~blocked_w;
  wire [1:0] up_next_w = ten_bit_w ? conv_data_i[9:8] : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Start decisions
  // A control write restarts in software-trigger mode unless the channel is off; aborts a busy conversion unless done arrives in the same cycle
  wire sw_start_w = wr_chan_w & chan_on_w & ~trig_sel_reg;
  wire hw_start_w = trg_rise_w & trig_sel_reg & (chan_reg != atc_pkg::CHAN_OFF)
                    & (state_reg != atc_pkg::ST_BUSY);
  wire abort_w = wr_chan_w & (state_reg == atc_pkg::ST_BUSY) & ~conv_done_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      atc_pkg::ST_IDLE: begin
        if (hw_start_w) begin
          state_next = atc_pkg::ST_BUSY;
        end else if (trig_sel_reg) begin
          state_next = atc_pkg::ST_ARMED;
        end
      end
      atc_pkg::ST_ARMED: begin
        if (hw_start_w) begin
          state_next = atc_pkg::ST_BUSY;
        end else if (~trig_sel_reg) begin
          state_next = atc_pkg::ST_IDLE;
        end
      end
      atc_pkg::ST_BUSY: begin
        if (finish_w | abort_w) begin
          state_next = trig_sel_reg ? atc_pkg::ST_ARMED : atc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = atc_pkg::ST_IDLE;
      end
    endcase
    // Software start overrides, also restarting a busy conversion
    if (sw_start_w) begin
      state_next = atc_pkg::ST_BUSY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, unused bits read zero
  wire active_w = (state_reg == atc_pkg::ST_BUSY);
  wire [7:0] rd_chan_w = {done_reg, 2'h0, chan_reg};
  wire [7:0] rd_trig_w = {active_w, trig_sel_reg, cmp_en_reg, cmp_ge_reg, 4'h0};
  wire [7:0] rd_rup_v_w = {6'h00, res_up_reg};
  wire [7:0] rd_cup_v_w = {6'h00, cmpv_up_reg};
  wire [7:0] rd_cfg_w = {4'h0, mode_reg, 2'h0};
  wire [7:0] rd_byte_w = hit_chan_w ? rd_chan_w :
                         hit_trig_w ? rd_trig_w :
                         hit_rup_w ? rd_rup_v_w :
                         hit_rlo_w ? res_lo_reg :
                         hit_cup_w ? rd_cup_v_w :
                         hit_clo_w ? cmpv_lo_reg :
                         hit_cfg_w ? rd_cfg_w : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= req_w;
      rdata_reg <= rd_w ? {24'h000000, rd_byte_w} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trg_s1_reg <= 1'b0;
      trg_s2_reg <= 1'b0;
      trg_s3_reg <= 1'b0;
    end else if (ce_i) begin
      trg_s1_reg <= hw_trigger_in_i;
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_reg <= atc_pkg::CHAN_RESET;
      trig_sel_reg <= 1'b0;
      cmp_en_reg <= 1'b0;
      cmp_ge_reg <= 1'b0;
      mode_reg <= atc_pkg::MODE_RESET;
      cmpv_up_reg <= 2'h0;
      cmpv_lo_reg <= atc_pkg::CMPV_RESET;
    end else if (ce_i) begin
      if (wr_chan_w) begin
        chan_reg <= chan_wr_w;
      end
      // Bits 3:0 are dropped, software keeps them zero
      if (wr_trig_w) begin
        trig_sel_reg <= wbyte_w[atc_pkg::TRIG_SEL_BIT];
        cmp_en_reg <= wbyte_w[atc_pkg::CMP_EN_BIT];
        cmp_ge_reg <= wbyte_w[atc_pkg::CMP_GE_BIT];
      end
      if (wr_cfg_w) begin
        mode_reg <= mode_wr_w;
      end
      if (wr_cup_w) begin
        cmpv_up_reg <= wbyte_w[1:0];
      end
      if (wr_clo_w) begin
        cmpv_lo_reg <= wbyte_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results, done flag and read lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_up_reg <= 2'h0;
      res_lo_reg <= atc_pkg::RES_RESET;
      done_reg <= 1'b0;
      lock_reg <= 1'b0;
      state_reg <= atc_pkg::ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (load_w) begin
        res_up_reg <= up_next_w;
        res_lo_reg <= conv_data_i[7:0];
      end else if (wr_cfg_w & (mode_wr_w != mode_reg)) begin
        // Old contents are stale anyway; clear upper so eight-bit reads zero
        res_up_reg <= 2'h0;
      end
      // Completion wins over a same-cycle clear
      if (load_w) begin
        done_reg <= 1'b1;
      end else if (wr_chan_w | rd_rlo_w) begin
        done_reg <= 1'b0;
      end
      if (rd_rlo_w | wr_cfg_w) begin
        lock_reg <= 1'b0;
      end else if (rd_rup_w & ten_bit_w) begin
        lock_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter-side outputs
  logic start_reg;
  logic abort_reg;
  logic ten_reg;
  logic [4:0] chan_out_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      ten_reg <= 1'b0;
      chan_out_reg <= atc_pkg::CHAN_RESET;
    end else if (ce_i) begin
      start_reg <= sw_start_w | hw_start_w;
      abort_reg <= abort_w;
      ten_reg <= ten_bit_w;
      chan_out_reg <= wr_chan_w ? chan_wr_w : chan_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign conv_start_o = start_reg;
  assign conv_abort_o = abort_reg;
  assign conv_ten_bit_o = ten_reg;
  assign conv_channel_o = chan_out_reg;

endmodule // atc_ctrl

//--- atc_ctrl_assertions.sv
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
module atc_ctrl_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic conv_ten_bit_o,
  input wire logic [4:0] conv_channel_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Shadow of trigger select, rebuilt from bus writes
  logic trig_reg;
  logic take;
  logic wr_chan;
  logic wr_cfg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr_chan = take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == atc_pkg::OFS_CHAN_START;
  assign wr_cfg = take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == atc_pkg::OFS_CONFIG;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_reg <= 1'b0;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == atc_pkg::OFS_TRIG_CMP) begin
      trig_reg <= wb_dat_i[atc_pkg::TRIG_SEL_BIT];
    end
  end
  sequence sw_go_s;
    wr_chan && !trig_reg && wb_dat_i[4:0] != atc_pkg::CHAN_OFF;
  endsequence
  sequence pulse_s;
    conv_start_o ##1 !conv_start_o;
  endsequence
  ack_after_take_a: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  sw_start_a: assert property (sw_go_s |=> pulse_s)
    else $error("no single start after control write");
  off_no_start_a: assert property (wr_chan && !trig_reg && wb_dat_i[4:0] == atc_pkg::CHAN_OFF |=> !conv_start_o)
    else $error("start with channel off");
  chan_follow_a: assert property (wr_chan |=> conv_channel_o == $past(wb_dat_i[4:0]))
    else $error("channel output wrong");
  // Resolution output follows the mode register, so it lags the write by two edges
  ten_bit_a: assert property (wr_cfg |-> ##2 conv_ten_bit_o == $past(wb_dat_i[3], 2))
    else $error("resolution output wrong");
  abort_cause_a: assert property (conv_abort_o |-> $past(wr_chan))
    else $error("abort without control write");
  freeze_hold_a: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(conv_start_o)
    && $stable(conv_abort_o) && $stable(conv_ten_bit_o) && $stable(conv_channel_o))
    else $error("output moved while clock enable low");
endmodule // atc_ctrl_chk
bind atc_ctrl atc_ctrl_chk #(.ADDR_W(ADDR_W)) atc_ctrl_chk_inst (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .conv_start_o, .conv_abort_o, .conv_ten_bit_o, .conv_channel_o);

//--- atc_ctrl_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module atc_ctrl_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic ce_i = 1'b1;
  logic hw_trigger_in_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [9:0] conv_data_i = 10'h000;
  logic [31:0] wb_dat_o;
  logic [4:0] conv_channel_o;
  logic wb_ack_o, conv_start_o, conv_abort_o, conv_ten_bit_o;
  int errors = 0, checks = 0, cycles = 0, starts = 0, aborts = 0;
  // Clock enable dropped once, in the freeze test
  atc_ctrl atc_ctrl_inst (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_trigger_in_i, .conv_done_i,
    .conv_data_i, .conv_start_o, .conv_abort_o, .conv_ten_bit_o, .conv_channel_o);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    // Unknown pulses are not counted, so they show up as a count mismatch
    starts += (conv_start_o === 1'b1);
    aborts += (conv_abort_o === 1'b1);
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic cnt_chk(input string n, input int e, input int g);
    checks++;
    if (g != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // Holds the request until ack is sampled, then drops it
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(a, e, q);
  endtask
  task automatic convert(input logic [9:0] v);
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    conv_data_i <= v;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    conv_data_i <= ~v;
  endtask
  function automatic logic hit(input logic t, input logic g, input logic [9:0] r, input logic [9:0] c);
    logic [9:0] x, y;
    x = t ? r : {2'h0, r[7:0]};
    y = t ? c : {2'h0, c[7:0]};
    return g ? x >= y : x < y;
  endfunction
  initial begin
    logic [9:0] d, p, cv, r;
    logic [4:0] ch;
    logic h;
    int s;
    void'($urandom(32'h49421b61));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rc(8'(4 * i), i == 0 ? 8'h1f : 8'h00);
    end
    wr(8'h08, 8'hff);
    wr(8'h10, 8'hff);
    rc(8'h08, 8'h00);
    rc(8'h10, 8'h03);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      ch = 5'($urandom % 31);
      d = 10'($urandom);
      s = starts;
      wr(8'h00, {3'h0, ch});
      rc(8'h04, 8'h80);
      cnt_chk("starts", s + 1, starts);
      convert(d);
      rc(8'h04, 8'h00);
      rc(8'h00, {3'h4, ch});
      rc(8'h08, 8'h00);
      wr(8'h00, {3'h0, ch});
      rc(8'h00, {3'h0, ch});
      convert(~d);
      rc(8'h0c, ~d[7:0]);
      rc(8'h00, {3'h0, ch});
    end
    s = starts;
    wr(8'h00, 8'h07);
    wr(8'h00, 8'h1f);
    rc(8'h04, 8'h00);
    cnt_chk("starts", s + 1, starts);
    $display("test eight_bit done");
    d = 10'($urandom);
    wr(8'h18, 8'h08);
    wr(8'h00, 8'h03);
    convert(d);
    rc(8'h08, {6'h0, d[9:8]});
    wr(8'h00, 8'h03);
    convert(~d);
    rc(8'h0c, d[7:0]);
    s = aborts;
    wr(8'h00, 8'h03);
    wr(8'h00, 8'h03);
    rc(8'h04, 8'h80);
    cnt_chk("aborts", s + 1, aborts);
    convert(~d);
    rc(8'h08, {6'h0, ~d[9:8]});
    rc(8'h0c, ~d[7:0]);
    $display("test ten_bit done");
    for (int k = 0; k < 8; k++) begin
      cv = 10'($urandom);
      d = k > 3 ? cv : 10'($urandom);
      p = 10'($urandom);
      wr(8'h18, {4'h0, k[0], 3'h0});
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h01);
      convert(p);
      rc(8'h0c, p[7:0]);
      wr(8'h10, {6'h0, cv[9:8]});
      wr(8'h14, cv[7:0]);
      wr(8'h04, {3'h1, k[1], 4'h0});
      rc(8'h04, {3'h1, k[1], 4'h0});
      wr(8'h00, 8'h01);
      convert(d);
      h = hit(k[0], k[1], d, cv);
      r = h ? d : p;
      rc(8'h00, {h, 7'h01});
      rc(8'h08, {6'h0, k[0] ? r[9:8] : 2'h0});
      rc(8'h0c, r[7:0]);
    end
    $display("test compare done");
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h40);
    s = starts;
    wr(8'h00, 8'h05);
    rc(8'h04, 8'h40);
    hw_trigger_in_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    hw_trigger_in_i <= 1'b0;
    cnt_chk("starts", s + 1, starts);
    d = 10'($urandom);
    convert(d);
    rc(8'h0c, d[7:0]);
    $display("test hw_trigger done");
    // A done pulse while clock enable is low must be lost
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h02);
    @(posedge clk_i);
    ce_i <= 1'b0;
    convert(d);
    ce_i <= 1'b1;
    rc(8'h04, 8'h80);
    rc(8'h00, 8'h02);
    convert(d);
    rc(8'h04, 8'h00);
    rc(8'h00, 8'h82);
    $display("test freeze done");
    give_verdict();
  end
endmodule // atc_ctrl_tb_top

//--- atc_pkg.sv
// Package with register map, field positions and encodings of the converter control block
package atc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] OFS_CHAN_START = 8'h00;
  localparam logic [7:0] OFS_TRIG_CMP = 8'h04;
  localparam logic [7:0] OFS_RES_UPPER = 8'h08;
  localparam logic [7:0] OFS_RES_LOWER = 8'h0c;
  localparam logic [7:0] OFS_CMPV_UPPER = 8'h10;
  localparam logic [7:0] OFS_CMPV_LOWER = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int DONE_BIT = 7;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int ACTIVE_BIT = 7;
  localparam int TRIG_SEL_BIT = 6;
  localparam int CMP_EN_BIT = 5;
  localparam int CMP_GE_BIT = 4;
  localparam int MODE_LSB = 2;
  localparam int MODE_W = 2;
  localparam int RES_W = 10;
  localparam int BYTE_W = 8;
  localparam int UPPER_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings and reset values
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [1:0] MODE_EIGHT = 2'h0;
  localparam logic [1:0] MODE_TEN = 2'h2;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] CMPV_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_BUSY
  } atc_state_t;

endpackage
